//--- design/ocs_pkg.sv
// Shared constants and types for the output clock stop control block.
// Assumes a single register clock; every user includes nothing and names items ocs_pkg::x.
package ocs_pkg;

    // ------------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------------
    localparam logic [7:0] ENG3_STOP_ADDR = 8'hB6;
    localparam logic [7:0] ENG2_STOP_ADDR = 8'hB7;
    localparam logic [7:0] ENG10_STOP_ADDR = 8'hB8;
    localparam logic [7:0] STOP_RESET = 8'h00;
    localparam logic [7:0] READ_ZERO = 8'h00;

    // ------------------------------------------------------------------
    // Field layout and codes
    // ------------------------------------------------------------------
    localparam int NUM_CHAN = 8;
    localparam int FIELD_W = 2;
    localparam int HALF_CHAN = 4;
    localparam logic [1:0] STOP_RUN0 = 2'h0;
    localparam logic [1:0] STOP_RUN1 = 2'h1;
    localparam logic [1:0] STOP_FALL = 2'h2;
    localparam logic [1:0] STOP_RISE = 2'h3;
    localparam logic [1:0] MUX_ENGINE = 2'h0;
    localparam logic [1:0] MUX_ALT = 2'h1;
    localparam logic [7:0] ALL_LOW = 8'h00;

    // ------------------------------------------------------------------
    // Per-channel halt state
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        OCS_RUN = 3'h1,
        OCS_HALT_LO = 3'h2,
        OCS_HALT_HI = 3'h4
    } ocs_halt_state_t;

endpackage

//--- design/ocs_chan_if.sv
// Interface between the register side and one output channel.
// Assumes both ends run on the same register clock.
`timescale 1ns/100ps
`default_nettype none
interface ocs_chan_if;
    logic [1:0] code;
    logic [1:0] route_sel;
    logic eng_lvl;
    logic eng_prev;
    logic alt_lvl;
    logic clk_out;

    modport ctl (output code, output route_sel, output eng_lvl, output eng_prev,
                 output alt_lvl, input clk_out);
    modport chan (input code, input route_sel, input eng_lvl, input eng_prev,
                  input alt_lvl, output clk_out);
endinterface
`default_nettype wire

//--- design/ocs_channel.sv
// One output channel: routes the selected source and halts it at an edge.
// Assumes the source levels are already synchronised to mclk.
`timescale 1ns/100ps
`default_nettype none
module ocs_channel (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic clk_en,
    ocs_chan_if.chan ch
);

    typedef struct packed {
        ocs_pkg::ocs_halt_state_t state;
        logic out;
    } ocs_chan_state_t;

    ocs_chan_state_t st_reg;
    ocs_chan_state_t st_next;
    logic route_eng;
    logic rise;
    logic fall;

    assign route_eng = (ch.route_sel == ocs_pkg::MUX_ENGINE);
    assign rise = ch.eng_lvl & ~ch.eng_prev;
    assign fall = ~ch.eng_lvl & ch.eng_prev;
    assign ch.clk_out = st_reg.out;

    // ------------------------------------------------------------------
    // Halt sequencing
    // ------------------------------------------------------------------
    always_comb begin
        st_next = st_reg;
        case (st_reg.state)
            ocs_pkg::OCS_RUN: begin
                if (route_eng) begin
                    st_next.out = ch.eng_lvl;
                    if (ch.code == ocs_pkg::STOP_FALL && fall) begin
                        st_next.state = ocs_pkg::OCS_HALT_LO;
                    end else if (ch.code == ocs_pkg::STOP_RISE && rise) begin
                        st_next.state = ocs_pkg::OCS_HALT_HI;
                    end
                end else if (ch.route_sel == ocs_pkg::MUX_ALT) begin
                    st_next.out = ch.alt_lvl;
                end else begin
                    st_next.out = 1'b0;
                end
            end
            ocs_pkg::OCS_HALT_LO: begin
                st_next.out = 1'b0;
                // Leave only on a source rise so the first high is full width.
                if (rise && !(route_eng && ch.code == ocs_pkg::STOP_FALL)) begin
                    st_next.out = 1'b1;
                    st_next.state = (route_eng && ch.code == ocs_pkg::STOP_RISE)
                        ? ocs_pkg::OCS_HALT_HI : ocs_pkg::OCS_RUN;
                end
            end
            ocs_pkg::OCS_HALT_HI: begin
                st_next.out = 1'b1;
                if (fall && !(route_eng && ch.code == ocs_pkg::STOP_RISE)) begin
                    st_next.out = 1'b0;
                    st_next.state = (route_eng && ch.code == ocs_pkg::STOP_FALL)
                        ? ocs_pkg::OCS_HALT_LO : ocs_pkg::OCS_RUN;
                end
            end
            default: begin
                st_next.state = ocs_pkg::OCS_RUN;
                st_next.out = 1'b0;
            end
        endcase
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            st_reg.state <= ocs_pkg::OCS_RUN;
            st_reg.out <= 1'b0;
        end else if (clk_en) begin
            st_reg <= st_next;
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    a_run_follows_src: assert property (
        @(posedge mclk) disable iff (!rst_n)
        clk_en && st_reg.state == ocs_pkg::OCS_RUN && route_eng && !ch.code[1]
        |=> ch.clk_out == $past(ch.eng_lvl))
        else $error("running output did not follow its divider");

    a_fall_stop_low: assert property (
        @(posedge mclk) disable iff (!rst_n)
        clk_en && st_reg.state == ocs_pkg::OCS_RUN && route_eng
        && ch.code == ocs_pkg::STOP_FALL && fall
        |=> st_reg.state == ocs_pkg::OCS_HALT_LO && !ch.clk_out)
        else $error("falling-edge stop did not halt low");

    a_rise_stop_high: assert property (
        @(posedge mclk) disable iff (!rst_n)
        clk_en && st_reg.state == ocs_pkg::OCS_RUN && route_eng
        && ch.code == ocs_pkg::STOP_RISE && rise
        |=> st_reg.state == ocs_pkg::OCS_HALT_HI && ch.clk_out)
        else $error("rising-edge stop did not halt high");

    a_halt_level_held: assert property (
        @(posedge mclk) disable iff (!rst_n)
        st_reg.state == ocs_pkg::OCS_HALT_LO |-> !ch.clk_out)
        else $error("halted-low output is not low");

    a_no_runt_resume: assert property (
        @(posedge mclk) disable iff (!rst_n)
        clk_en && st_reg.state == ocs_pkg::OCS_HALT_LO && !rise
        |=> st_reg.state == ocs_pkg::OCS_HALT_LO && !ch.clk_out)
        else $error("halted-low output left without a source rise");

    a_route_gates_stop: assert property (
        @(posedge mclk) disable iff (!rst_n)
        clk_en && st_reg.state == ocs_pkg::OCS_RUN && !route_eng
        |=> st_reg.state == ocs_pkg::OCS_RUN)
        else $error("stop acted on an output not routed from its divider");

    a_alt_route: assert property (
        @(posedge mclk) disable iff (!rst_n)
        clk_en && st_reg.state == ocs_pkg::OCS_RUN && ch.route_sel == ocs_pkg::MUX_ALT
        |=> ch.clk_out == $past(ch.alt_lvl))
        else $error("alternate route did not pass the alternate clock");

endmodule // ocs_channel
`default_nettype wire

//--- design/ocs_output_clock_stop.sv
// Top of the output clock stop control: stop registers and eight output channels.
// Assumes divider and alternate clocks are slow against mclk and arrive asynchronously.
`timescale 1ns/100ps
`default_nettype none
// Notes on behaviour
// - Codes 00 and 01 leave the output running with no stop.
// - Code 10 halts the output at a falling edge and holds it low.
// - Code 11 halts the output at a rising edge and holds it high.
// - Engine-3 register bits 1:0 halt divider A, output 4.
// - Engine-3 register bits 3:2 halt divider B, output 5.
// - Engine-3 register bits 5:4 halt divider C, output 6.
// - Engine-3 register bits 7:6 halt divider D, output 7.
// - Engine-2 register bits 1:0 halt divider A, output 0.
// - Engine-2 register bits 3:2 halt divider B, output 1.
// - Engine-2 register bits 5:4 halt divider C, output 2.
// - Engine-2 register bits 7:6 halt divider D, output 3.
// - Mux code 00 routes the engine divider to its output, in order.
module ocs_output_clock_stop (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic clk_en,
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr_en,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_rd_en,
    output logic [7:0] reg_rdata,
    input wire logic [3:0] eng2_div_clk,
    input wire logic [3:0] eng3_div_clk,
    input wire logic [7:0] alt_clk,
    input wire logic [15:0] out_mux_sel,
    output logic cfg_output_clock_0,
    output logic cfg_output_clock_1,
    output logic cfg_output_clock_2,
    output logic cfg_output_clock_3,
    output logic cfg_output_clock_4,
    output logic cfg_output_clock_5,
    output logic cfg_output_clock_6,
    output logic cfg_output_clock_7
);

    typedef struct packed {
        logic [7:0] eng3_stop;
        logic [7:0] eng2_stop;
        logic [7:0] eng10_stop;
        logic [7:0] rdata;
        logic [7:0] src_meta;
        logic [7:0] src_sync;
        logic [7:0] src_prev;
        logic [7:0] alt_meta;
        logic [7:0] alt_sync;
    } ocs_top_state_t;

    ocs_top_state_t st_reg;
    ocs_top_state_t st_next;
    logic [15:0] stop_codes;
    logic [7:0] clk_vec;

    // ------------------------------------------------------------------
    // Register access and input synchronisers
    // ------------------------------------------------------------------
    always_comb begin
        st_next = st_reg;
        st_next.src_meta = {eng3_div_clk, eng2_div_clk};
        st_next.src_sync = st_reg.src_meta;
        st_next.src_prev = st_reg.src_sync;
        st_next.alt_meta = alt_clk;
        st_next.alt_sync = st_reg.alt_meta;
        if (reg_wr_en) begin
            case (reg_addr)
                ocs_pkg::ENG3_STOP_ADDR: st_next.eng3_stop = reg_wdata;
                ocs_pkg::ENG2_STOP_ADDR: st_next.eng2_stop = reg_wdata;
                ocs_pkg::ENG10_STOP_ADDR: st_next.eng10_stop = reg_wdata;
                default: st_next.eng3_stop = st_reg.eng3_stop;
            endcase
        end
        if (reg_rd_en) begin
            case (reg_addr)
                ocs_pkg::ENG3_STOP_ADDR: st_next.rdata = st_reg.eng3_stop;
                ocs_pkg::ENG2_STOP_ADDR: st_next.rdata = st_reg.eng2_stop;
                ocs_pkg::ENG10_STOP_ADDR: st_next.rdata = st_reg.eng10_stop;
                default: st_next.rdata = ocs_pkg::READ_ZERO;
            endcase
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            st_reg.eng3_stop <= ocs_pkg::STOP_RESET;
            st_reg.eng2_stop <= ocs_pkg::STOP_RESET;
            st_reg.eng10_stop <= ocs_pkg::STOP_RESET;
            st_reg.rdata <= ocs_pkg::READ_ZERO;
            st_reg.src_meta <= ocs_pkg::ALL_LOW;
            st_reg.src_sync <= ocs_pkg::ALL_LOW;
            st_reg.src_prev <= ocs_pkg::ALL_LOW;
            st_reg.alt_meta <= ocs_pkg::ALL_LOW;
            st_reg.alt_sync <= ocs_pkg::ALL_LOW;
        end else if (clk_en) begin
            st_reg <= st_next;
        end
    end

    assign reg_rdata = st_reg.rdata;

    // ------------------------------------------------------------------
    // Channels: 0 to 3 take engine-2 fields, 4 to 7 take engine-3 fields
    // ------------------------------------------------------------------
    assign stop_codes = {st_reg.eng3_stop, st_reg.eng2_stop};

    genvar gi;
    generate
        for (gi = 0; gi < ocs_pkg::NUM_CHAN; gi++) begin : g_chan
            ocs_chan_if link ();
            assign link.code = stop_codes[gi*ocs_pkg::FIELD_W +: ocs_pkg::FIELD_W];
            assign link.route_sel = out_mux_sel[gi*ocs_pkg::FIELD_W +: ocs_pkg::FIELD_W];
            assign link.eng_lvl = st_reg.src_sync[gi];
            assign link.eng_prev = st_reg.src_prev[gi];
            assign link.alt_lvl = st_reg.alt_sync[gi];
            assign clk_vec[gi] = link.clk_out;
            ocs_channel u_chan (
                .mclk(mclk),
                .rst_n(rst_n),
                .clk_en(clk_en),
                .ch(link)
            );
        end
    endgenerate

    assign cfg_output_clock_0 = clk_vec[0];
    assign cfg_output_clock_1 = clk_vec[1];
    assign cfg_output_clock_2 = clk_vec[2];
    assign cfg_output_clock_3 = clk_vec[3];
    assign cfg_output_clock_4 = clk_vec[4];
    assign cfg_output_clock_5 = clk_vec[5];
    assign cfg_output_clock_6 = clk_vec[6];
    assign cfg_output_clock_7 = clk_vec[7];

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    a_eng3_reg_write: assert property (
        @(posedge mclk) disable iff (!rst_n)
        clk_en && reg_wr_en && reg_addr == ocs_pkg::ENG3_STOP_ADDR
        |=> st_reg.eng3_stop == $past(reg_wdata))
        else $error("engine-3 stop register did not take the write");

    a_eng2_field_map: assert property (
        @(posedge mclk) disable iff (!rst_n)
        clk_en && st_reg.eng2_stop[7:6] == ocs_pkg::STOP_FALL
        && out_mux_sel[7:6] == ocs_pkg::MUX_ENGINE
        && st_reg.src_prev[3] && !st_reg.src_sync[3]
        |=> !cfg_output_clock_3)
        else $error("engine-2 divider D falling stop did not hold output 3 low");

endmodule // ocs_output_clock_stop
`default_nettype wire

//--- verification/tb_top.sv
// Self-checking testbench for the output clock stop control block.
// Assumes the design package, interface and modules under design/ are compiled first.
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    localparam int ENG_HP = 8;
    localparam int ALT_HP = 5;
    // Starting the clocks at a known level avoids a false falling edge at time zero.
    logic mclk = 1'b0;
    logic rst_n;
    logic clk_en;
    logic [7:0] reg_addr;
    logic reg_wr_en;
    logic [7:0] reg_wdata;
    logic reg_rd_en;
    logic [7:0] reg_rdata;
    logic [3:0] eng2_div_clk = 4'h0;
    logic [3:0] eng3_div_clk = 4'h0;
    logic [7:0] alt_clk = 8'h00;
    logic [15:0] out_mux_sel;
    wire [7:0] outs;
    logic eng_run;
    logic [1:0] code;
    logic [7:0] addr_sel;
    logic [7:0] tog;
    logic [7:0] shrt;
    int error_cnt = 0;
    int total_checks = 0;
    int tick = 0;
    logic [7:0] addrs [3];
    logic [7:0] run_val [2];

    ocs_output_clock_stop dut_u (
        .mclk(mclk), .rst_n(rst_n), .clk_en(clk_en), .reg_addr(reg_addr),
        .reg_wr_en(reg_wr_en), .reg_wdata(reg_wdata), .reg_rd_en(reg_rd_en),
        .reg_rdata(reg_rdata), .eng2_div_clk(eng2_div_clk), .eng3_div_clk(eng3_div_clk),
        .alt_clk(alt_clk), .out_mux_sel(out_mux_sel),
        .cfg_output_clock_0(outs[0]), .cfg_output_clock_1(outs[1]),
        .cfg_output_clock_2(outs[2]), .cfg_output_clock_3(outs[3]),
        .cfg_output_clock_4(outs[4]), .cfg_output_clock_5(outs[5]),
        .cfg_output_clock_6(outs[6]), .cfg_output_clock_7(outs[7])
    );

    // ------------------------------------------------------------------
    // Clock and source clocks
    // ------------------------------------------------------------------
    initial begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end

    // Divider clocks can be frozen so that a toggling output proves the alternate route.
    always @(negedge mclk) begin
        tick <= tick + 1;
        if (eng_run && (tick % ENG_HP == 0)) begin
            eng2_div_clk <= ~eng2_div_clk;
            eng3_div_clk <= ~eng3_div_clk;
        end
        if (tick % ALT_HP == 0) begin
            alt_clk <= ~alt_clk;
        end
    end

    // ------------------------------------------------------------------
    // Access and checking tasks
    // ------------------------------------------------------------------
    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic reg_write(input logic [7:0] addr, input logic [7:0] data);
        @(negedge mclk);
        reg_addr = addr;
        reg_wdata = data;
        reg_wr_en = 1'b1;
        @(negedge mclk);
        reg_wr_en = 1'b0;
    endtask

    task automatic reg_read(input logic [7:0] addr, input logic [7:0] exp, input string name);
        @(negedge mclk);
        reg_addr = addr;
        reg_rd_en = 1'b1;
        @(negedge mclk);
        reg_rd_en = 1'b0;
        check(name, reg_rdata, exp);
    endtask

    // Records which outputs toggled and which showed a run shorter than hp cycles.
    task automatic watch(input int n, input int hp, output logic [7:0] t, output logic [7:0] s);
        logic [7:0] last;
        logic [7:0] started;
        int len [8];
        last = outs;
        started = 8'h00;
        t = 8'h00;
        s = 8'h00;
        foreach (len[i]) len[i] = 0;
        repeat (n) begin
            @(negedge mclk);
            for (int i = 0; i < 8; i++) begin
                if (outs[i] !== last[i]) begin
                    if (started[i] && len[i] < hp) s[i] = 1'b1;
                    started[i] = 1'b1;
                    t[i] = 1'b1;
                    len[i] = 1;
                end else begin
                    len[i]++;
                end
            end
            last = outs;
        end
    endtask

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge mclk);
        error_cnt++;
        $display("[FAIL] watchdog expected done seen timeout");
        tally_and_finish();
    end

    // ------------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------------
    initial begin
        rst_n = 1'b0;
        clk_en = 1'b1;
        reg_addr = 8'h00;
        reg_wr_en = 1'b0;
        reg_wdata = 8'h00;
        reg_rd_en = 1'b0;
        out_mux_sel = 16'h0000;
        eng_run = 1'b1;
        addrs = '{ocs_pkg::ENG3_STOP_ADDR, ocs_pkg::ENG2_STOP_ADDR, ocs_pkg::ENG10_STOP_ADDR};
        run_val = '{8'h55, 8'h00};
        repeat (2) @(negedge mclk);
        check("out_in_reset", outs, 8'h00);
        repeat (2) @(negedge mclk);
        rst_n = 1'b1;
        foreach (addrs[k]) reg_read(addrs[k], ocs_pkg::STOP_RESET, "reset_value");
        foreach (addrs[k]) begin
            reg_write(addrs[k], 8'hA5 ^ 8'(k));
            reg_read(addrs[k], 8'hA5 ^ 8'(k), "read_back");
            reg_write(addrs[k], 8'h00);
        end
        reg_write(8'hB9, 8'hFF);
        reg_read(8'hB9, ocs_pkg::READ_ZERO, "unmapped_read");
        clk_en = 1'b0;
        reg_write(ocs_pkg::ENG3_STOP_ADDR, 8'hFF);
        clk_en = 1'b1;
        reg_read(ocs_pkg::ENG3_STOP_ADDR, 8'h00, "frozen_write");
        $display("test registers done");
        foreach (run_val[k]) begin
            reg_write(ocs_pkg::ENG3_STOP_ADDR, run_val[k]);
            reg_write(ocs_pkg::ENG2_STOP_ADDR, run_val[k]);
            watch(6 * ENG_HP, ENG_HP, tog, shrt);
            check("run_toggle", tog, 8'hFF);
            check("run_short", shrt, 8'h00);
        end
        $display("test running codes done");
        for (int i = 0; i < 8; i++) begin
            for (int c = 2; c < 4; c++) begin
                code = c[1:0];
                addr_sel = (i < 4) ? ocs_pkg::ENG2_STOP_ADDR : ocs_pkg::ENG3_STOP_ADDR;
                reg_write(addr_sel, 8'(code) << (2 * (i % 4)));
                repeat (3 * ENG_HP) @(negedge mclk);
                watch(4 * ENG_HP, ENG_HP, tog, shrt);
                check("halt_toggle", tog, ~(8'h01 << i));
                check("halt_level", {7'h00, outs[i]}, {7'h00, code[0]});
                reg_write(addr_sel, 8'h00);
                watch(6 * ENG_HP, ENG_HP, tog, shrt);
                check("resume_short", shrt, 8'h00);
                check("resume_toggle", tog, 8'hFF);
            end
        end
        $display("test halt and resume done");
        // Route away first, so that the stop codes written next find no routed divider.
        out_mux_sel = 16'h5555;
        eng_run = 1'b0;
        reg_write(ocs_pkg::ENG3_STOP_ADDR, 8'hFF);
        reg_write(ocs_pkg::ENG2_STOP_ADDR, 8'hFF);
        repeat (10) @(negedge mclk);
        watch(6 * ALT_HP, ALT_HP, tog, shrt);
        check("alt_toggle", tog, 8'hFF);
        check("alt_short", shrt, 8'h00);
        out_mux_sel = 16'hAAAA;
        repeat (10) @(negedge mclk);
        watch(4 * ALT_HP, ALT_HP, tog, shrt);
        check("reserved_level", outs | tog, 8'h00);
        out_mux_sel = 16'h0000;
        eng_run = 1'b1;
        repeat (3 * ENG_HP) @(negedge mclk);
        watch(4 * ENG_HP, ENG_HP, tog, shrt);
        check("engine_halt_toggle", tog, 8'h00);
        check("engine_halt_level", outs, 8'hFF);
        $display("test routing done");
        tally_and_finish();
    end
endmodule // tb_top
`default_nettype wire
